// File: smsp_top.sv
// smsp_top: full-duplex serial port, master or slave, msb first, 8-bit bytes
// assumes cpu strobes and pins are synchronous to clk; pads resolve the enables
// Function
// - master loads written byte into shifter, sends msb first on mosi
// - only the master clocks; each byte is exchanged both ways at once
// - four polarity/phase choices; both ends must use the same one
// - with soft select the pin is ignored, select level comes from a bit
// - slave with phase zero: select high between bytes, else write collides
// - in master mode, master and enable bits stay set only while select is high
// - master transfer starts as soon as a byte is written
// - end of byte sets done flag; interrupt if enabled and not masked
// - master clears done by status access then data read
// - slave clears done by status access then data read or write
// - data writes ignored while done is set until status is read or written
// - slave shifts written byte out on miso only when master clocks
// - select low in master mode sets fault, clears enable and master
// - fault clears after status read then control write
// - fault blocks setting enable and master except in the clearing write
// - byte arriving while done set flags overrun, keeps the first byte
// - overrun clears on a status register read
// - write during a transfer is dropped, flags collision, no interrupt
// - received bytes go to a buffer read apart from the shifter
// - master rate selects divide by 4, 8, 16, 32, 64 or 128
// - phase zero captures on first edge, phase one on second edge
`timescale 1ns/1ns
module smsp_top
    import smsp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cr_wr,
    input wire logic [7:0] cr_wdata,
    input wire logic csr_rd,
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    input wire logic dr_rd,
    input wire logic dr_wr,
    input wire logic [7:0] dr_wdata,
    input wire logic cpu_int_mask,
    output logic [7:0] cr_q,
    output logic [7:0] csr_q,
    output logic [7:0] dr_q,
    output logic irq,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_b_i
);
    // ****************************************
    // state
    // ****************************************
    logic serial_irq_enable_ff, spe_ff, master_select_ff, cpol_ff, cpha_ff;
    logic [2:0] rate_ff;
    logic ssm_ff, ssi_ff;
    logic transfer_done_flag_ff, transfer_done_flag_arm_ff, write_collision_flag_ff, write_collision_flag_arm_ff, ovr_ff, mode_fault_flag_ff, mode_fault_flag_arm_ff;
    logic nxt_transfer_done_flag, nxt_transfer_done_flag_arm, nxt_write_collision_flag, nxt_write_collision_flag_arm, nxt_ovr, nxt_mode_fault_flag;
    logic nxt_mode_fault_flag_arm, nxt_spe, nxt_master_select;
    logic irq_ff, sck_oe_ff, mosi_oe_ff, miso_oe_ff;
    smsp_mst_t mst_st_ff;
    logic [6:0] div_cnt_ff;
    logic [4:0] edge_cnt_ff;
    logic sck_ff, sck_prev_ff, started_ff;
    logic [2:0] cap_cnt_ff;
    logic [7:0] tx_sr_ff, rx_sr_ff, rx_buf_ff;
    logic ss_int, csr_acc, sck_now, din, edge_en, sck_chg, lead_edge, trail_edge;
    logic cap_edge, sh_edge, byte_done, mst_run_w, tick, active_m, active_s, active;
    logic dr_blocked, dr_load, mst_start, write_collision_flag_evt, transfer_done_flag_clr, write_collision_flag_clr;
    logic mode_fault_flag_evt, mode_fault_flag_clr, allow_set, push_ok, ovr_evt, pop;
    logic [6:0] half_cnt;
    logic [7:0] rx_next;
    logic [10:0] run_len_ff;

    smsp_fifo_if #(.WIDTH(DATA_W)) rxq ();

    smsp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .link(rxq)
    );

    // ****************************************
    // selection and decoding
    // ****************************************
    // soft select level
    assign ss_int = ssm_ff ? ssi_ff : ss_b_i;
    assign csr_acc = csr_rd | csr_wr;
    assign sck_now = master_select_ff ? sck_ff : sck_i;
    assign din = master_select_ff ? miso_i : mosi_i;
    assign edge_en = spe_ff & (master_select_ff | ~ss_int);
    assign sck_chg = edge_en & (sck_now != sck_prev_ff);
    assign lead_edge = sck_chg & (sck_prev_ff == cpol_ff);
    assign trail_edge = sck_chg & (sck_prev_ff != cpol_ff);
    assign cap_edge = cpha_ff ? trail_edge : lead_edge;
    assign sh_edge = (cpha_ff ? lead_edge : trail_edge) & ~(cpha_ff & ~started_ff);
    assign byte_done = cap_edge & (cap_cnt_ff == BIT_LAST);
    assign rx_next = {rx_sr_ff[6:0], din};
    assign half_cnt = (rate_ff == RATE_DIV4) ? HALF_DIV4 :
                      (rate_ff == RATE_DIV8) ? HALF_DIV8 :
                      (rate_ff == RATE_DIV16) ? HALF_DIV16 :
                      (rate_ff == RATE_DIV32) ? HALF_DIV32 :
                      (rate_ff == RATE_DIV64) ? HALF_DIV64 : HALF_DIV128;
    assign mst_run_w = (mst_st_ff == mst_run);
    assign tick = mst_run_w & (div_cnt_ff == half_cnt - 7'h01);
    assign active_m = mst_run_w | (sck_ff != sck_prev_ff);
    // slave phase one busy from first edge
    // slave phase zero busy while selected
    assign active_s = spe_ff & (cpha_ff ? (started_ff | (cap_cnt_ff != 3'h0)) : ~ss_int);
    assign active = master_select_ff ? active_m : active_s;
    assign dr_blocked = transfer_done_flag_ff & ~transfer_done_flag_arm_ff;
    assign dr_load = dr_wr & ~dr_blocked & ~active;
    assign mst_start = dr_load & master_select_ff & spe_ff;
    assign write_collision_flag_evt = dr_wr & ~dr_blocked & active;
    // slave clears by read or write
    assign transfer_done_flag_clr = transfer_done_flag_arm_ff & (dr_rd | (dr_wr & ~master_select_ff));
    assign write_collision_flag_clr = write_collision_flag_arm_ff & (dr_rd | dr_wr);
    assign mode_fault_flag_evt = master_select_ff & ~ss_int;
    assign mode_fault_flag_clr = mode_fault_flag_arm_ff & cr_wr;
    assign allow_set = ~mode_fault_flag_ff | mode_fault_flag_clr;
    assign push_ok = byte_done & ~transfer_done_flag_ff & ~rxq.out_valid & rxq.in_ready;
    assign ovr_evt = byte_done & ~push_ok;
    assign rxq.in_valid = push_ok;
    assign rxq.in_data = rx_next;
    assign rxq.out_ready = ~transfer_done_flag_ff;
    assign pop = rxq.out_valid & ~transfer_done_flag_ff;

    // ****************************************
    // flag next values, set wins over clear
    // ****************************************
    // done on byte arrival
    assign nxt_transfer_done_flag = pop | (transfer_done_flag_ff & ~transfer_done_flag_clr);
    assign nxt_transfer_done_flag_arm = transfer_done_flag_ff & ~transfer_done_flag_clr & (transfer_done_flag_arm_ff | csr_acc);
    assign nxt_write_collision_flag = write_collision_flag_evt | (write_collision_flag_ff & ~write_collision_flag_clr);
    assign nxt_write_collision_flag_arm = write_collision_flag_ff & ~write_collision_flag_clr & (write_collision_flag_arm_ff | csr_acc);
    assign nxt_ovr = ovr_evt | (ovr_ff & ~csr_rd);
    assign nxt_mode_fault_flag = mode_fault_flag_evt | (mode_fault_flag_ff & ~mode_fault_flag_clr);
    assign nxt_mode_fault_flag_arm = mode_fault_flag_ff & ~mode_fault_flag_clr & (mode_fault_flag_arm_ff | csr_rd);
    assign nxt_spe = mode_fault_flag_evt ? 1'b0 : (cr_wr ? (cr_wdata[CR_PORT_EN] & allow_set) : spe_ff);
    assign nxt_master_select = mode_fault_flag_evt ? 1'b0 : (cr_wr ? (cr_wdata[CR_MASTER] & allow_set) : master_select_ff);

    // ****************************************
    // control and status registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {serial_irq_enable_ff, cpol_ff, cpha_ff} <= {CR_RESET[CR_IRQ_EN], CR_RESET[CR_CPOL],
                CR_RESET[CR_CPHA]};
            rate_ff <= {CR_RESET[CR_RATE2], CR_RESET[CR_RATE1], CR_RESET[CR_RATE0]};
            {spe_ff, master_select_ff} <= {CR_RESET[CR_PORT_EN], CR_RESET[CR_MASTER]};
            {ssm_ff, ssi_ff} <= {CSR_RESET[CSR_SSM], CSR_RESET[CSR_SSI]};
        end
        else
        begin
            if (cr_wr)
            begin
                {serial_irq_enable_ff, cpol_ff, cpha_ff} <= {cr_wdata[CR_IRQ_EN], cr_wdata[CR_CPOL],
                    cr_wdata[CR_CPHA]};
                rate_ff <= {cr_wdata[CR_RATE2], cr_wdata[CR_RATE1], cr_wdata[CR_RATE0]};
            end
            if (csr_wr)
            begin
                {ssm_ff, ssi_ff} <= {csr_wdata[CSR_SSM], csr_wdata[CSR_SSI]};
            end
            spe_ff <= nxt_spe;
            master_select_ff <= nxt_master_select;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {transfer_done_flag_ff, transfer_done_flag_arm_ff, write_collision_flag_ff, write_collision_flag_arm_ff} <= 4'h0;
            {ovr_ff, mode_fault_flag_ff, mode_fault_flag_arm_ff} <= 3'h0;
        end
        else
        begin
            {transfer_done_flag_ff, transfer_done_flag_arm_ff, write_collision_flag_ff, write_collision_flag_arm_ff} <= {nxt_transfer_done_flag, nxt_transfer_done_flag_arm,
                nxt_write_collision_flag, nxt_write_collision_flag_arm};
            {ovr_ff, mode_fault_flag_ff, mode_fault_flag_arm_ff} <= {nxt_ovr, nxt_mode_fault_flag, nxt_mode_fault_flag_arm};
        end
    end

    // ****************************************
    // interrupt request and pin enables
    // ****************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {irq_ff, sck_oe_ff, mosi_oe_ff, miso_oe_ff} <= 4'h0;
        end
        else
        begin
            // flags gated by enable and cpu mask
            irq_ff <= serial_irq_enable_ff & (transfer_done_flag_ff | mode_fault_flag_ff | ovr_ff) & ~cpu_int_mask;
            sck_oe_ff <= spe_ff & master_select_ff;
            mosi_oe_ff <= spe_ff & master_select_ff;
            miso_oe_ff <= spe_ff & ~master_select_ff & ~ss_int;
        end
    end

    // ****************************************
    // master clock generator
    // ****************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mst_st_ff <= mst_idle;
            div_cnt_ff <= 7'h00;
            edge_cnt_ff <= 5'h00;
            sck_ff <= 1'b0;
        end
        else
        begin
            unique case (mst_st_ff)
                mst_idle:
                begin
                    div_cnt_ff <= 7'h00;
                    edge_cnt_ff <= 5'h00;
                    sck_ff <= cpol_ff;
                    if (mst_start)
                    begin
                        mst_st_ff <= mst_run;
                    end
                end
                mst_run:
                begin
                    div_cnt_ff <= tick ? 7'h00 : div_cnt_ff + 7'h01;
                    if (tick)
                    begin
                        sck_ff <= ~sck_ff;
                        edge_cnt_ff <= edge_cnt_ff + 5'h01;
                    end
                    if (!(spe_ff && master_select_ff) || (tick && edge_cnt_ff == EDGE_LAST))
                    begin
                        mst_st_ff <= mst_idle;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // shifter
    // ****************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sck_prev_ff <= 1'b0;
            cap_cnt_ff <= 3'h0;
            started_ff <= 1'b0;
            tx_sr_ff <= 8'h00;
            rx_sr_ff <= 8'h00;
        end
        else
        begin
            sck_prev_ff <= sck_now;
            cap_cnt_ff <= (!edge_en || dr_load) ? 3'h0 : cap_cnt_ff + 3'(cap_edge);
            started_ff <= (edge_en && !dr_load && !byte_done) && (started_ff || lead_edge);
            if (dr_load)
            begin
                tx_sr_ff <= dr_wdata;
            end
            else if (sh_edge)
            begin
                tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
            end
            if (cap_edge)
            begin
                rx_sr_ff <= rx_next;
            end
        end
    end

    // ****************************************
    // receive buffer
    // ****************************************
    // buffer apart from shifter
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_buf_ff <= 8'h00;
        end
        else if (pop)
        begin
            rx_buf_ff <= rxq.out_data;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cr_q = {serial_irq_enable_ff, spe_ff, rate_ff[2], master_select_ff, cpol_ff, cpha_ff, rate_ff[1:0]};
    assign csr_q = {transfer_done_flag_ff, write_collision_flag_ff, ovr_ff, mode_fault_flag_ff, 2'h0, ssm_ff, ssi_ff};
    assign dr_q = rx_buf_ff;
    assign irq = irq_ff;
    assign sck_o = sck_ff;
    assign sck_oe = sck_oe_ff;
    assign mosi_o = tx_sr_ff[7];
    assign mosi_oe = mosi_oe_ff;
    assign miso_o = tx_sr_ff[7];
    assign miso_oe = miso_oe_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_master_load;
        mst_start |=> mst_run_w && (tx_sr_ff == $past(dr_wdata)) && (mosi_o == $past(dr_wdata[7]));
    endproperty
    a_master_load: assert property (p_master_load) else $error("master load wrong");

    property p_master_start;
        (mst_st_ff == mst_idle && dr_wr && master_select_ff && spe_ff && !dr_blocked && !active) |=>
            mst_run_w;
    endproperty
    a_master_start: assert property (p_master_start) else $error("no master start");

    // cycles spent in one master byte
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_len_ff <= 11'h000;
        end
        else
        begin
            run_len_ff <= mst_run_w ? run_len_ff + 11'h001 : 11'h000;
        end
    end

    property p_byte_span;
        mst_run_w |-> (run_len_ff < ({6'h00, EDGE_LAST} + 11'h001) * {4'h0, half_cnt});
    endproperty
    a_byte_span: assert property (p_byte_span) else $error("master byte never ends");

    property p_rate4;
        (mst_start && rate_ff == RATE_DIV4) |=> sck_ff == $past(cpol_ff) ##2 sck_ff != cpol_ff;
    endproperty
    a_rate4: assert property (p_rate4) else $error("fastest rate wrong");

    property p_mode_fault_flag_set;
        (master_select_ff && !ss_int) |=> mode_fault_flag_ff && !master_select_ff && !spe_ff;
    endproperty
    a_mode_fault_flag_set: assert property (p_mode_fault_flag_set) else $error("mode fault not taken");

    property p_master_needs_ss;
        (!ss_int && !cr_wr) |=> !master_select_ff;
    endproperty
    a_master_needs_ss: assert property (p_master_needs_ss) else $error("master kept");

    property p_mode_fault_flag_block;
        (mode_fault_flag_ff && !mode_fault_flag_arm_ff && cr_wr) |=> !spe_ff && !master_select_ff;
    endproperty
    a_mode_fault_flag_block: assert property (p_mode_fault_flag_block) else $error("enable set in fault");

    property p_mode_fault_flag_clear;
        (mode_fault_flag_arm_ff && cr_wr && ss_int) |=> !mode_fault_flag_ff;
    endproperty
    a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear) else $error("fault not cleared");

    property p_soft_select;
        (ssm_ff && ssi_ff && !mode_fault_flag_ff && !csr_wr) |=> !mode_fault_flag_ff;
    endproperty
    a_soft_select: assert property (p_soft_select) else $error("pin not ignored");

    property p_overrun;
        (byte_done && transfer_done_flag_ff) |=> ovr_ff && $stable(rx_buf_ff);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");

    property p_ovr_clear;
        (csr_rd && !ovr_evt) |=> !ovr_ff;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

    property p_write_collision_flag;
        write_collision_flag_evt |=> write_collision_flag_ff && $stable(mst_st_ff);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missed");

    property p_write_collision_flag_no_irq;
        (write_collision_flag_ff && !transfer_done_flag_ff && !mode_fault_flag_ff && !ovr_ff) |=> !irq_ff;
    endproperty
    a_write_collision_flag_no_irq: assert property (p_write_collision_flag_no_irq) else $error("collision irq");

    property p_dr_blocked;
        (dr_wr && dr_blocked && !sh_edge) |=> $stable(tx_sr_ff) && !$rose(write_collision_flag_ff);
    endproperty
    a_dr_blocked: assert property (p_dr_blocked) else $error("write not ignored");

    property p_irq;
        (transfer_done_flag_ff && serial_irq_enable_ff && !cpu_int_mask) |=> irq_ff;
    endproperty
    a_irq: assert property (p_irq) else $error("no done interrupt");

    property p_master_clear;
        (master_select_ff && transfer_done_flag_arm_ff && dr_rd && !pop) |=> !transfer_done_flag_ff;
    endproperty
    a_master_clear: assert property (p_master_clear) else $error("done not cleared");

    property p_slave_clear;
        (!master_select_ff && transfer_done_flag_arm_ff && dr_wr && !pop) |=> !transfer_done_flag_ff;
    endproperty
    a_slave_clear: assert property (p_slave_clear) else $error("slave done stuck");

    property p_rx_path;
        push_ok |-> ##2 (dr_q == $past(rx_next, 2)) && transfer_done_flag_ff;
    endproperty
    a_rx_path: assert property (p_rx_path) else $error("byte not buffered");

    c_master_byte: cover property (mst_start ##[32:1000] transfer_done_flag_ff);
    c_slave_byte: cover property (!master_select_ff && byte_done);
    c_mode_fault: cover property (mode_fault_flag_evt);
    c_overrun: cover property (ovr_evt);
endmodule : smsp_top

// File: smsp_pkg.sv
// smsp_pkg: constants, field positions and state type of the serial port
// assumes one 25 MHz cpu clock; all cycle counts are in that clock
package smsp_pkg;
    // ****************************************
    // widths and buffering
    // ****************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned CPU_CLK_HZ = 25000000;
    // ****************************************
    // control register fields
    // ****************************************
    localparam int unsigned CR_IRQ_EN = 7;
    localparam int unsigned CR_PORT_EN = 6;
    localparam int unsigned CR_RATE2 = 5;
    localparam int unsigned CR_MASTER = 4;
    localparam int unsigned CR_CPOL = 3;
    localparam int unsigned CR_CPHA = 2;
    localparam int unsigned CR_RATE1 = 1;
    localparam int unsigned CR_RATE0 = 0;
    localparam logic [7:0] CR_RESET = 8'h00;
    // ****************************************
    // control/status register fields
    // ****************************************
    localparam int unsigned CSR_DONE = 7;
    localparam int unsigned CSR_WRITE_COLLISION_FLAG = 6;
    localparam int unsigned CSR_OVR = 5;
    localparam int unsigned CSR_MODE_FAULT_FLAG = 4;
    localparam int unsigned CSR_SSM = 1;
    localparam int unsigned CSR_SSI = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;
    // ****************************************
    // rate codes {rate2, rate1, rate0} and half sck periods in cpu cycles
    // ****************************************
    localparam logic [2:0] RATE_DIV4 = 3'h4;
    localparam logic [2:0] RATE_DIV8 = 3'h0;
    localparam logic [2:0] RATE_DIV16 = 3'h1;
    localparam logic [2:0] RATE_DIV32 = 3'h6;
    localparam logic [2:0] RATE_DIV64 = 3'h2;
    localparam logic [2:0] RATE_DIV128 = 3'h3;
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV8 = 7'h04;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV32 = 7'h10;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [4:0] EDGE_LAST = 5'h0f;
    localparam logic [2:0] BIT_LAST = 3'h7;
    typedef enum logic {mst_idle, mst_run} smsp_mst_t;
endpackage : smsp_pkg

// File: smsp_fifo_if.sv
// smsp_fifo_if: valid/ready link between the shifter and the receive fifo
// assumes both sides run on the same clock
`timescale 1ns/1ns
interface smsp_fifo_if #(parameter int unsigned WIDTH = 8);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, input in_data, input out_ready,
        output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
        input in_ready, input out_valid, input out_data);
endinterface : smsp_fifo_if

// File: smsp_fifo.sv
// smsp_fifo: synchronous fifo, registered storage, honest full and empty
// assumes one clock and an active low asynchronous reset
`timescale 1ns/1ns
module smsp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
)(
    input wire logic clk,
    input wire logic rst_b,
    smsp_fifo_if.fifo link
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign link.in_ready = ~full;
    assign link.out_valid = ~empty;
    assign link.out_data = mem_ff[rd_ptr_ff[AW-1:0]];
    assign push = link.in_valid & ~full;
    assign pop = link.out_ready & ~empty;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= link.in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
        end
    end
endmodule : smsp_fifo

// File: smsp_slave_model.sv
// smsp_slave_model: far-end slave, polarity 0 phase 0, msb first
// assumes sck idles low and the bench pulses load before each byte
`timescale 1ns/1ns
module smsp_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic load,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh_ff;
    assign miso = sh_ff[7];
    always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
    // change on trailing edge, junk after the byte
    always @(posedge load or negedge sck)
        if (load) sh_ff <= tx_byte;
        else sh_ff <= {sh_ff[6:0], ~sh_ff[7]};
endmodule : smsp_slave_model

// File: spi_master_slave_port_tb.sv
// spi_master_slave_port_tb: master exchanges against the slave model
// assumes smsp_top and smsp_slave_model are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module spi_master_slave_port_tb;
    import smsp_pkg::*;
    logic clk, rst_b, cr_wr, csr_rd, csr_wr, dr_rd, dr_wr, m_load, ss_b_i, msk, b_sck, b_mosi;
    logic [7:0] wd, cr_q, csr_q, dr_q, m_tx, m_rx, r, s, mm;
    logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_w;
    logic [2:0] rates [3] = '{RATE_DIV4, RATE_DIV16, RATE_DIV32};
    logic [7:0] q [$];
    int num_errors = 0, compares = 0, cyc = 0;
    smsp_top dut_u (.clk(clk), .rst_b(rst_b), .cr_wr(cr_wr), .cr_wdata(wd), .csr_rd(csr_rd),
        .csr_wr(csr_wr), .csr_wdata(wd), .dr_rd(dr_rd), .dr_wr(dr_wr), .dr_wdata(wd),
        .cpu_int_mask(msk), .cr_q(cr_q), .csr_q(csr_q), .dr_q(dr_q), .irq(irq),
        .sck_i(sck_oe ? sck_o : b_sck), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(b_mosi),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .ss_b_i(ss_b_i));
    smsp_slave_model peer_u (.sck(sck_oe ? sck_o : 1'b0), .mosi(mosi_o), .load(m_load),
        .tx_byte(m_tx), .miso(miso_w), .rx_byte(m_rx));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic end_of_test;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // kind: 0 cr write, 1 csr write, 2 data write with peer load, 3 csr read,
    // 4 data read, 5 data write only
    task automatic op(input int k, input logic [7:0] d);
        @(posedge clk);
        cr_wr <= k == 0; csr_wr <= k == 1; dr_wr <= k == 2 || k == 5;
        csr_rd <= k == 3; dr_rd <= k == 4; m_load <= k == 2; wd <= d;
        @(posedge clk);
        {cr_wr, csr_wr, dr_wr, csr_rd, dr_rd, m_load} <= '0;
        repeat (2) @(negedge clk);
    endtask : op
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    // ****************************************
    // watcher: each done flag delivers the oldest expected byte
    // ****************************************
    always @(posedge csr_q[7])
    begin
        @(negedge clk);
        if (q.size() > 0) `CHK(dr_q, q.pop_front())
    end
    initial
    begin
        {cr_wr, csr_wr, dr_wr, csr_rd, dr_rd, m_load} = '0;
        wd = 8'h00; m_tx = 8'h00; ss_b_i = 1'b1; rst_b = 1'b0;
        {msk, b_sck, b_mosi} = 3'h0;
        void'($urandom(90495));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK(cr_q, 8'h00)
        `CHK(csr_q, 8'h00)
        // rate first, select high, then master
        op(0, 8'h00);
        op(1, 8'h03);
        @(posedge clk) ss_b_i <= 1'b0;
        foreach (rates[i])
        begin
            r = $urandom;
            s = $urandom;
            @(posedge clk) msk <= i[0];
            op(0, {2'b11, rates[i][2], 3'b100, rates[i][1:0]});
            q.push_back(s);
            m_tx <= s;
            op(2, r);
            op(5, ~r);
            for (int n = 0; n < 3000 && csr_q[7] !== 1'b1; n++) @(negedge clk);
            repeat (2) @(negedge clk);
            `CHK(m_rx, r)
            `CHK(csr_q[6], 1'b1)
            `CHK(irq, !msk)
            op(3, 8'h00);
            op(4, 8'h00);
            `CHK(csr_q[7], 1'b0)
        end
        `CHK(csr_q[4], 1'b0)
        op(1, 8'h00);
        `CHK(csr_q[4], 1'b1)
        `CHK({cr_q[6], cr_q[4]}, 2'b00)
        op(0, 8'h50);
        `CHK({cr_q[6], cr_q[4]}, 2'b00)
        @(posedge clk) ss_b_i <= 1'b1;
        op(3, 8'h00);
        op(0, 8'h50);
        `CHK(csr_q[4], 1'b0)
        `CHK({cr_q[6], cr_q[4]}, 2'b11)
        // slave, phase one, soft select low
        op(0, 8'h44);
        op(1, 8'h02);
        r = $urandom;
        s = $urandom;
        q.push_back(r);
        op(5, s);
        // bench master launches on first edge, captures on second
        for (int b = 7; b >= 0; b--)
        begin
            @(posedge clk);
            b_sck <= 1'b1;
            b_mosi <= r[b];
            repeat (4) @(negedge clk);
            mm[b] = miso_o;
            @(posedge clk);
            b_sck <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(negedge clk);
        `CHK(mm, s)
        `CHK(csr_q[7], 1'b1)
        op(5, 8'hff);
        `CHK(csr_q[6], 1'b0)
        op(3, 8'h00);
        op(5, 8'h00);
        `CHK(csr_q[7], 1'b0)
        end_of_test();
    end
endmodule : spi_master_slave_port_tb
